/* pho_regs.sv */
// pho_regs: charge option and processor-hot option registers with the alarm pulse logic
// assumes a smbus engine that hands over decoded word accesses, analog comparators whose
// raw levels arrive asynchronously, and an envelope selector held elsewhere
//
// What this block does
// RQ1: bit 7 picks register or lower-of-pin limit
// RQ2: bit 6 picks charge or discharge monitoring
// RQ3: critical threshold code, 5% steps, default 150%
// RQ4: critical code map 110%..230%, then 50% steps
// RQ5: limit above 3.584A clamps critical at 230%
// RQ6: bits 10:9 pick critical deglitch time
// RQ7: bit 8 picks over-current 125% or 200%
// RQ8: system voltage trips low after 20us
// RQ9: bits 7:6 pick system voltage threshold
// RQ10: bit 5 holds alarm low until host clear
// RQ11: bits 4:3 pick minimum alarm pulse width
// RQ12: host writing 0 to bit 2 releases alarm
// RQ13: nominal threshold 110% of limit, selectable deglitch
// RQ14: empty envelope disables the alarm entirely
// RQ15: adapter removal masks four alarm sources
// RQ16: enabled tripped source pulls alarm low
`timescale 1ns/1ps
module pho_regs #(
	parameter int P_CYC_400US = pho_pkg::CYC_400US,
	parameter int P_CYC_800US = pho_pkg::CYC_800US,
	parameter int P_CYC_1MS   = pho_pkg::CYC_1MS,
	parameter int P_CYC_6MS   = pho_pkg::CYC_6MS,
	parameter int P_CYC_12MS  = pho_pkg::CYC_12MS,
	parameter int P_CYC_50MS  = pho_pkg::CYC_50MS
) (
	input  wire logic               core_clk_i,
	input  wire logic               rstn_i,
	input  wire pho_pkg::pho_cmd_t  cmd_i,
	output logic [15:0]             rdata_o,
	output logic                    rdata_valid_o,
	input  wire pho_pkg::pho_sense_t sense_i,
	input  wire logic [6:0]         external_limit_pin_i,
	input  wire logic [6:0]         programmed_input_limit_i,
	input  wire logic [6:0]         envelope_sel_i,
	input  wire logic               single_cell_i,
	output logic [6:0]              effective_limit_o,
	output logic                    battery_current_monitor_out_sel_o,
	output logic [8:0]              critical_input_current_pct_o,
	output logic                    critical_out_of_range_o,
	output logic [9:0]              over_current_pct_o,
	output logic [13:0]             nominal_input_current_ma_o,
	output logic [12:0]             system_voltage_comparator_mv_o,
	output logic                    processor_hot_alarm_n_o
);
	localparam int W = pho_pkg::CNT_W;

	// ---- register file ----
	logic [15:0] opt2, next_opt2;
	logic [15:0] opt0, next_opt0;
	logic [15:0] next_rdata;
	logic        next_rvalid;

	// reserved bits never store, so they always read as zero
	always_comb begin
		next_opt2   = opt2;
		next_opt0   = opt0;
		next_rdata  = rdata_o;
		next_rvalid = 1'b0;
		if (cmd_i.valid && cmd_i.write) begin
			if (cmd_i.code == pho_pkg::ADDR_OPT2)
				next_opt2 = cmd_i.wdata & pho_pkg::OPT2_WMSK;
			if (cmd_i.code == pho_pkg::ADDR_OPT0)
				next_opt0 = cmd_i.wdata & pho_pkg::OPT0_WMSK; // RQ12
		end else if (cmd_i.valid) begin
			next_rvalid = 1'b1;
			case (cmd_i.code)
				pho_pkg::ADDR_OPT2: next_rdata = opt2;
				pho_pkg::ADDR_OPT0: next_rdata = opt0;
				default:            next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			opt2          <= pho_pkg::OPT2_RST;
			opt0          <= pho_pkg::OPT0_RST;
			rdata_o       <= 16'h0000;
			rdata_valid_o <= 1'b0;
		end else begin
			opt2          <= next_opt2;
			opt0          <= next_opt0;
			rdata_o       <= next_rdata;
			rdata_valid_o <= next_rvalid;
		end
	end

	// ---- input synchronisers: analog levels and pin code arrive unclocked ----
	pho_pkg::pho_sense_t sense_s1, sense_s2;
	logic [6:0]          pin_s1, pin_s2;
	logic                batp_d, adapter_good_source_d;

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			sense_s1 <= '0;
			sense_s2 <= '0;
			pin_s1   <= 7'h00;
			pin_s2   <= 7'h00;
			batp_d   <= 1'b0;
			adapter_good_source_d   <= 1'b0;
		end else begin
			sense_s1 <= sense_i;
			sense_s2 <= sense_s1;
			pin_s1   <= external_limit_pin_i;
			pin_s2   <= pin_s1;
			batp_d   <= sense_s2.bat_present;
			adapter_good_source_d   <= sense_s2.adapter_good;
		end
	end

	// ---- deglitch for critical, nominal and system voltage comparators ----
	logic [W-1:0] dg_limit [3];
	logic [2:0]   dg_raw;
	logic [2:0]   dg_out;

	always_comb begin
		case (opt0[pho_pkg::CRIT_DG_LSB +: 2]) // RQ6
			2'b00:   dg_limit[0] = W'(pho_pkg::CYC_10US);
			2'b01:   dg_limit[0] = W'(pho_pkg::CYC_100US);
			2'b10:   dg_limit[0] = W'(P_CYC_400US);
			default: dg_limit[0] = W'(P_CYC_800US);
		endcase
		// stated as a maximum, so the count is the full figure and never more
		dg_limit[1] = opt0[pho_pkg::NOM_DG_BIT] ? W'(P_CYC_50MS) : W'(P_CYC_1MS); // RQ13
		dg_limit[2] = W'(pho_pkg::CYC_20US); // RQ8
		dg_raw      = {sense_s2.system_voltage_comparator, sense_s2.nom, sense_s2.crit};
	end

	for (genvar g = 0; g < 3; g++) begin : g_dg
		pho_deglitch u_dg (
			.core_clk_i (core_clk_i),
			.rstn_i     (rstn_i),
			.level_i    (dg_raw[g]),
			.limit_i    (dg_limit[g]),
			.level_o    (dg_out[g])
		);
	end

	// ---- threshold computation ----
	logic [6:0]  next_eff;
	logic [8:0]  next_crit;
	logic        next_oor;
	logic [9:0]  next_ocp;
	logic [17:0] lim_ma;
	logic [13:0] next_nom;
	logic [12:0] next_system_voltage_comparator;
	logic [4:0]  crit_code;

	always_comb begin
		next_eff = programmed_input_limit_i;
		if (opt2[pho_pkg::EXT_LIM_BIT] && pin_s2 < programmed_input_limit_i) // RQ1
			next_eff = pin_s2;
		crit_code = opt0[pho_pkg::CRIT_THR_LSB +: 5]; // RQ3
		next_oor  = 1'b0;
		if (crit_code <= 5'h01)
			next_crit = pho_pkg::PCT_FLOOR; // RQ4
		else if (crit_code <= pho_pkg::CODE_FINE_TOP)
			next_crit = pho_pkg::PCT_FIVE_BASE + 9'(crit_code) * 9'h005; // RQ4
		else if (crit_code != pho_pkg::CODE_OOR)
			next_crit = pho_pkg::PCT_COARSE + 9'(crit_code - 5'h1a) * 9'h032; // RQ4
		else begin
			next_crit = 9'h000;
			next_oor  = 1'b1;
		end
		// large limits would push the trip past what the sense path can measure
		if (effective_limit_o > pho_pkg::LIM_CLAMP_CODE) begin // RQ5
			next_crit = pho_pkg::PCT_CLAMP;
			next_oor  = 1'b0;
		end
		next_ocp = opt0[pho_pkg::OCP_SEL_BIT] ? {next_crit, 1'b0} // RQ7
			: 10'(({3'b000, next_crit} * 12'h005) >> 2); // twelve bits: 450 x 5 wraps in eleven
		lim_ma    = 18'(effective_limit_o) * pho_pkg::LIM_MA_STEP;
		next_nom  = 14'((lim_ma * 18'h0000b) / 18'h0000a); // RQ13
		next_system_voltage_comparator = single_cell_i ? pho_pkg::SYSTEM_VOLTAGE_COMPARATOR_SINGLE_MV[opt0[pho_pkg::SYSTEM_VOLTAGE_COMPARATOR_THR_LSB +: 2]] // RQ9
			: pho_pkg::SYSTEM_VOLTAGE_COMPARATOR_MULTI_MV[opt0[pho_pkg::SYSTEM_VOLTAGE_COMPARATOR_THR_LSB +: 2]];
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			effective_limit_o                 <= 7'h00;
			battery_current_monitor_out_sel_o <= 1'b0;
			critical_input_current_pct_o      <= 9'h000;
			critical_out_of_range_o           <= 1'b0;
			over_current_pct_o                <= 10'h000;
			nominal_input_current_ma_o        <= 14'h0000;
			system_voltage_comparator_mv_o    <= 13'h0000;
		end else begin
			effective_limit_o                 <= next_eff;
			battery_current_monitor_out_sel_o <= opt2[pho_pkg::MON_SEL_BIT]; // RQ2
			critical_input_current_pct_o      <= next_crit;
			critical_out_of_range_o           <= next_oor;
			over_current_pct_o                <= next_ocp;
			nominal_input_current_ma_o        <= next_nom;
			system_voltage_comparator_mv_o    <= next_system_voltage_comparator;
		end
	end

	// ---- alarm sources and pulse sequencer ----
	logic [6:0]          src_event;
	logic [6:0]          src_mask;
	logic                trip;
	pho_pkg::pho_state_t state, next_state;
	logic [W-1:0]        pulse_cnt, next_pulse_cnt, pw_limit;
	logic                next_alarm_n;

	always_comb begin
		src_event = 7'h00;
		src_event[pho_pkg::SRC_CMP]  = sense_s2.cmp;
		src_event[pho_pkg::SRC_CRIT] = dg_out[0];
		src_event[pho_pkg::SRC_NOM]  = dg_out[1];
		src_event[pho_pkg::SRC_DCHG] = sense_s2.dchg;
		src_event[pho_pkg::SRC_SYSTEM_VOLTAGE_COMPARATOR] = dg_out[2];
		src_event[pho_pkg::SRC_BATP] = sense_s2.bat_present & ~batp_d; // rising edge one-shot
		src_event[pho_pkg::SRC_ADAPTER_GOOD_SOURCE] = adapter_good_source_d & ~sense_s2.adapter_good; // falling edge one-shot
		src_mask = envelope_sel_i;
		if (!sense_s2.adapter_present)
			src_mask = src_mask & ~pho_pkg::SRC_ADAPTER_ONLY; // RQ15
		trip = |(src_event & src_mask); // RQ16
		case (opt0[pho_pkg::PULSE_W_LSB +: 2]) // RQ11
			2'b00:   pw_limit = W'(pho_pkg::CYC_100US);
			2'b01:   pw_limit = W'(P_CYC_1MS);
			2'b10:   pw_limit = W'(P_CYC_12MS);
			default: pw_limit = W'(P_CYC_6MS);
		endcase
	end

	// a new trip during a pulse restarts the minimum width
	always_comb begin
		next_state     = state;
		next_pulse_cnt = pulse_cnt;
		case (state)
			pho_pkg::PHO_IDLE: begin
				next_pulse_cnt = '0;
				if (trip)
					next_state = opt0[pho_pkg::PULSE_EXT_BIT] ? pho_pkg::PHO_HOLD : pho_pkg::PHO_PULSE; // RQ10
			end
			pho_pkg::PHO_PULSE: begin
				if (trip)
					next_pulse_cnt = '0; // RQ16
				else if (pulse_cnt + 1'b1 >= pw_limit)
					next_state = pho_pkg::PHO_IDLE; // RQ11
				else
					next_pulse_cnt = pulse_cnt + 1'b1;
			end
			pho_pkg::PHO_HOLD: begin
				if (!opt0[pho_pkg::HOST_CLR_BIT])
					next_state = pho_pkg::PHO_IDLE; // RQ12
			end
			default: next_state = pho_pkg::PHO_IDLE;
		endcase
		if (envelope_sel_i == 7'h00)
			next_state = pho_pkg::PHO_IDLE; // RQ14
		next_alarm_n = (next_state == pho_pkg::PHO_IDLE);
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			state                   <= pho_pkg::PHO_IDLE;
			pulse_cnt               <= '0;
			processor_hot_alarm_n_o <= 1'b1;
		end else begin
			state                   <= next_state;
			pulse_cnt               <= next_pulse_cnt;
			processor_hot_alarm_n_o <= next_alarm_n;
		end
	end

	// ---- checks ----
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	a_mon_select: assert property (cmd_i.valid && cmd_i.write && cmd_i.code == pho_pkg::ADDR_OPT2 // RQ2
		|=> ##1 battery_current_monitor_out_sel_o == $past(cmd_i.wdata[6], 2)) else $error("monitor select wrong");
	a_limit_lower: assert property (opt2[7] && pin_s2 < programmed_input_limit_i // RQ1
		|=> effective_limit_o == $past(pin_s2)) else $error("lower limit not taken");
	a_crit_default: assert property (opt0[15:11] == 5'h09 && effective_limit_o <= 7'h38 // RQ3
		|=> critical_input_current_pct_o == 9'd150) else $error("critical 150 percent wrong");
	a_crit_range: assert property (opt0[15:11] == 5'h1f && effective_limit_o <= 7'h38 // RQ4
		|=> critical_out_of_range_o) else $error("out of range code missed");
	a_crit_clamp: assert property (effective_limit_o > 7'h38 // RQ5
		|=> critical_input_current_pct_o == 9'd230) else $error("critical clamp missing");
	a_ocp_low: assert property (!opt0[8] && opt0[15:11] == 5'h0e && effective_limit_o <= 7'h38 // RQ7
		|=> over_current_pct_o == 10'h0da) else $error("over-current 125 percent wrong");
	a_system_voltage_comparator_thresh: assert property (opt0[7:6] == 2'b00 && !single_cell_i // RQ9
		|=> system_voltage_comparator_mv_o == 13'd5750) else $error("system voltage threshold wrong");
	a_trip_alarm: assert property (trip && envelope_sel_i != 7'h00 && state != pho_pkg::PHO_HOLD // RQ16
		|=> !processor_hot_alarm_n_o) else $error("trip did not raise alarm");
	a_ext_hold: assert property (state == pho_pkg::PHO_HOLD && opt0[2] && envelope_sel_i != 7'h00 // RQ10
		|=> !processor_hot_alarm_n_o) else $error("extended alarm released early");
	a_host_clear: assert property (state == pho_pkg::PHO_HOLD && !opt0[2] // RQ12
		|=> processor_hot_alarm_n_o) else $error("host clear ignored");
	a_env_off: assert property (envelope_sel_i == 7'h00 // RQ14
		|=> processor_hot_alarm_n_o ##1 processor_hot_alarm_n_o || envelope_sel_i != 7'h00 || trip)
		else $error("alarm active with empty envelope");
	a_adapter_mask: assert property (!sense_s2.adapter_present // RQ15
		|-> (src_mask & pho_pkg::SRC_ADAPTER_ONLY) == 7'h00) else $error("adapter sources not masked");
	a_pulse_min: assert property (state == pho_pkg::PHO_PULSE && pulse_cnt + 22'd8 < pw_limit // RQ11
		&& envelope_sel_i != 7'h00 |=> !processor_hot_alarm_n_o) else $error("pulse ended early");
endmodule : pho_regs

/* pho_pkg.sv */
// pho_pkg: constants, reset values and carrier types of the alarm option registers
// assumes a 40 MHz core clock; the smbus engine outside delivers decoded word accesses
package pho_pkg;
	// register command codes
	localparam logic [7:0]  ADDR_OPT2 = 8'h38;
	localparam logic [7:0]  ADDR_OPT0 = 8'h3c;
	// reset values and writable bits
	localparam logic [15:0] OPT2_RST  = 16'h0080;
	localparam logic [15:0] OPT2_WMSK = 16'h00c0;
	localparam logic [15:0] OPT0_RST  = 16'h4b54;
	localparam logic [15:0] OPT0_WMSK = 16'hfffe;
	// field positions
	localparam int EXT_LIM_BIT   = 7;
	localparam int MON_SEL_BIT   = 6;
	localparam int CRIT_THR_LSB  = 11;
	localparam int CRIT_DG_LSB   = 9;
	localparam int OCP_SEL_BIT   = 8;
	localparam int SYSTEM_VOLTAGE_COMPARATOR_THR_LSB  = 6;
	localparam int PULSE_EXT_BIT = 5;
	localparam int PULSE_W_LSB   = 3;
	localparam int HOST_CLR_BIT  = 2;
	localparam int NOM_DG_BIT    = 1;
	// envelope source bits
	localparam int SRC_CMP = 6, SRC_CRIT = 5, SRC_NOM = 4, SRC_DCHG = 3;
	localparam int SRC_SYSTEM_VOLTAGE_COMPARATOR = 2, SRC_BATP = 1, SRC_ADAPTER_GOOD_SOURCE = 0;
	localparam logic [6:0]  SRC_ADAPTER_ONLY = 7'h33;
	// limit code above which the critical threshold is clamped (64 ma units)
	localparam logic [6:0]  LIM_CLAMP_CODE = 7'h38;
	localparam logic [8:0]  PCT_CLAMP      = 9'h0e6;
	localparam logic [8:0]  PCT_FLOOR      = 9'h06e;
	localparam logic [8:0]  PCT_FIVE_BASE  = 9'h069;
	localparam logic [8:0]  PCT_COARSE     = 9'h0fa;
	localparam logic [4:0]  CODE_FINE_TOP  = 5'h19;
	localparam logic [4:0]  CODE_OOR       = 5'h1f;
	localparam logic [17:0] LIM_MA_STEP    = 18'h00040;
	// system voltage thresholds in mv, multi-cell and single-cell
	localparam logic [12:0] SYSTEM_VOLTAGE_COMPARATOR_MULTI_MV  [4] = '{13'h1676, 13'h1770, 13'h186a, 13'h1964};
	localparam logic [12:0] SYSTEM_VOLTAGE_COMPARATOR_SINGLE_MV [4] = '{13'h0b22, 13'h0c1c, 13'h0d16, 13'h0e10};
	// timing
	localparam int CYC_PER_US  = 40;
	localparam int T_10US      = 10;
	localparam int T_20US      = 20;
	localparam int T_100US     = 100;
	localparam int T_400US     = 400;
	localparam int T_800US     = 800;
	localparam int T_1000US    = 1000;
	localparam int T_6000US    = 6000;
	localparam int T_12000US   = 12000;
	localparam int T_50000US   = 50000;
	localparam int CYC_10US    = T_10US * CYC_PER_US;
	localparam int CYC_20US    = T_20US * CYC_PER_US;
	localparam int CYC_100US   = T_100US * CYC_PER_US;
	localparam int CYC_400US   = T_400US * CYC_PER_US;
	localparam int CYC_800US   = T_800US * CYC_PER_US;
	localparam int CYC_1MS     = T_1000US * CYC_PER_US;
	localparam int CYC_6MS     = T_6000US * CYC_PER_US;
	localparam int CYC_12MS    = T_12000US * CYC_PER_US;
	localparam int CYC_50MS    = T_50000US * CYC_PER_US;
	localparam int CNT_W       = 22;

	// decoded smbus word access
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  code;
		logic [15:0] wdata;
	} pho_cmd_t;

	// raw comparator and presence levels from the analog side
	typedef struct packed {
		logic cmp;
		logic crit;
		logic nom;
		logic dchg;
		logic system_voltage_comparator;
		logic bat_present;
		logic adapter_good;
		logic adapter_present;
	} pho_sense_t;

	typedef enum logic [2:0] {
		PHO_IDLE  = 3'b001,
		PHO_PULSE = 3'b010,
		PHO_HOLD  = 3'b100
	} pho_state_t;
endpackage : pho_pkg

/* pho_deglitch.sv */
// pho_deglitch: passes a level once it has stood high for a programmed number of cycles
// assumes the input is already synchronous to core_clk_i
`timescale 1ns/1ps
module pho_deglitch (
	input  wire logic                    core_clk_i,
	input  wire logic                    rstn_i,
	input  wire logic                    level_i,
	input  wire logic [pho_pkg::CNT_W-1:0] limit_i,
	output logic                         level_o
);
	logic [pho_pkg::CNT_W-1:0] cnt;
	logic [pho_pkg::CNT_W-1:0] next_cnt;
	logic                      next_level;

	// any low cycle restarts the wait, so short glitches never pass
	always_comb begin
		next_cnt   = cnt;
		next_level = 1'b0;
		if (!level_i) begin
			next_cnt = '0;
		end else if (cnt + 1'b1 >= limit_i) begin
			next_level = 1'b1;
		end else begin
			next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			cnt     <= '0;
			level_o <= 1'b0;
		end else begin
			cnt     <= next_cnt;
			level_o <= next_level;
		end
	end

	a_drop_on_low: assert property (@(posedge core_clk_i) disable iff (!rstn_i) // RQ8
		!level_i |=> !level_o) else $error("deglitch output stayed high after input fell");
endmodule : pho_deglitch

/* pho_host.sv */
// pho_host: host model issuing decoded word accesses to the alarm option registers
// assumes the bench calls its tasks and compares read words against exp_q
`timescale 1ns/1ps
module pho_host (
	input  wire logic         core_clk_i,
	output pho_pkg::pho_cmd_t cmd_o
);
	logic [15:0] exp_q [$];

	// idle port shows the inverse of the last access, so a stale copy cannot pass
	initial cmd_o = '{1'b0, 1'b0, 8'hff, 16'hffff};

	// one word per access, valid for exactly one taking edge
	task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		#2;
		cmd_o = '{1'b1, w, a, d};
		@(posedge core_clk_i);
		#2;
		cmd_o = '{1'b0, ~w, ~a, ~d};
	endtask : access

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		access(1'b1, a, d);
	endtask : wr

	// expected word is queued before the request leaves
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		access(1'b0, a, 16'h0000);
	endtask : rd

	// ending an extended alarm takes a write of 0 to the host clear bit
	task automatic clear_alarm(input logic [15:0] r0);
		wr(pho_pkg::ADDR_OPT0, r0 & 16'hfffb);
	endtask : clear_alarm
endmodule : pho_host

/* tb_top.sv */
// tb_top: self-checking bench for the alarm option registers and alarm pulse logic
// assumes shortened timing parameters; sense levels are driven here in the analog side's place
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin fails++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, a); end end
module tb_top;
	logic              core_clk_i;
	logic              rstn_i;
	logic [7:0]        sense_v;
	logic [6:0]        ext_pin, prog, env;
	logic              single;
	logic [15:0]       rdata, exp_w, r0, r2;
	logic              rdv, sel, oor, alarm_n;
	logic [6:0]        eff;
	logic [8:0]        pct;
	logic [9:0]        ovr;
	logic [13:0]       nom_ma;
	logic [12:0]       mv;
	pho_pkg::pho_cmd_t cmd;
	int                fails, checks_done, seed, d, w, e;
	int                dgt [4] = '{pho_pkg::CYC_10US, pho_pkg::CYC_100US, pho_pkg::CYC_400US, 30};
	int                pwt [4] = '{4000, 40, 80, 60};

	pho_host host (.core_clk_i(core_clk_i), .cmd_o(cmd));
	// the 400 us deglitch keeps its full count of 16000 cycles, so its default is exercised
	pho_regs #(.P_CYC_800US(30), .P_CYC_1MS(40), .P_CYC_6MS(60), .P_CYC_12MS(80),
		.P_CYC_50MS(100)) dut (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cmd_i(cmd), .rdata_o(rdata), .rdata_valid_o(rdv),
		.sense_i(pho_pkg::pho_sense_t'(sense_v)), .external_limit_pin_i(ext_pin),
		.programmed_input_limit_i(prog), .envelope_sel_i(env), .single_cell_i(single),
		.effective_limit_o(eff), .battery_current_monitor_out_sel_o(sel),
		.critical_input_current_pct_o(pct), .critical_out_of_range_o(oor), .over_current_pct_o(ovr),
		.nominal_input_current_ma_o(nom_ma), .system_voltage_comparator_mv_o(mv),
		.processor_hot_alarm_n_o(alarm_n));

	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end

	task automatic stop_test;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#2;
	endtask : tick

	// raise one sense level, count cycles to the alarm, drop it, count the low time
	task automatic measure(input int sb, input int bound);
		d = 0;
		w = 0;
		sense_v[sb] = 1'b1;
		while (alarm_n !== 1'b0 && d < bound) begin
			tick(1);
			d++;
		end
		sense_v[sb] = 1'b0;
		while (alarm_n === 1'b0 && w < bound) begin
			tick(1);
			w++;
		end
	endtask : measure

	// bounded wait for the alarm to release; sync flops get a few cycles to flush
	task automatic settle;
		int n;
		n = 0;
		while (alarm_n !== 1'b1 && n < 6000) begin
			tick(1);
			n++;
		end
		if (n == 6000) begin
			fails++;
			stop_test();
		end
		else
			tick(5);
	endtask : settle

	task automatic put0;
		host.wr(pho_pkg::ADDR_OPT0, r0);
	endtask : put0

	// read results are matched against the oldest queued expectation
	always @(posedge core_clk_i) begin
		if (rstn_i === 1'b1 && rdv === 1'b1) begin
			if (host.exp_q.size() == 0) begin
				fails++;
				$display("wrong value rdata expected none seen %0h", rdata);
			end
			else begin
				exp_w = host.exp_q.pop_front();
				`CHK("rdata", exp_w, rdata)
			end
		end
	end

	// watchdog: a hang counts as a mismatch and still ends in the verdict
	initial begin
		repeat (90000) @(posedge core_clk_i);
		fails++;
		stop_test();
	end

	initial begin
		seed = 32'h433d;
		rstn_i = 1'b0;
		sense_v = 8'h01;
		ext_pin = 7'h7f;
		prog = 7'h20;
		env = 7'h00;
		single = 1'b0;
		r0 = 16'h4b54;
		tick(10);
		rstn_i = 1'b1;
		// reset values, reserved bits, unmapped code
		host.rd(pho_pkg::ADDR_OPT2, 16'h0080);
		host.rd(pho_pkg::ADDR_OPT0, 16'h4b54);
		host.rd(8'h3f, 16'h0000);
		host.wr(pho_pkg::ADDR_OPT2, 16'hffff);
		host.wr(pho_pkg::ADDR_OPT0, 16'hffff);
		host.wr(8'h3f, 16'h1234);
		host.rd(pho_pkg::ADDR_OPT2, 16'h00c0);
		host.rd(pho_pkg::ADDR_OPT0, 16'hfffe);
		host.rd(8'h3f, 16'h0000);
		tick(3);
		`CHK("mon_sel", 1'b1, sel)
		put0();
		$display("test registers done");
		// limit source select against random pin and register limits
		for (int i = 0; i < 6; i++) begin
			ext_pin = 7'($random(seed));
			prog = 7'($random(seed));
			r2 = i[0] ? 16'h0080 : 16'h0000;
			host.wr(pho_pkg::ADDR_OPT2, r2);
			tick(5);
			e = (r2[7] && ext_pin < prog) ? ext_pin : prog;
			`CHK("eff", e, eff)
			`CHK("mon_sel", 1'b0, sel)
			`CHK("nom_ma", (e * 64 * 11) / 10, nom_ma)
		end
		ext_pin = 7'h7f;
		prog = 7'h20;
		$display("test limits done");
		// every critical code, over-current select alternating
		for (int c = 0; c < 32; c++) begin
			r0[15:11] = 5'(c);
			r0[8] = c[0];
			put0();
			tick(4);
			e = c < 2 ? 110 : c < 26 ? 105 + 5 * c : c < 31 ? 250 + 50 * (c - 26) : 0;
			`CHK("crit_pct", e, pct)
			`CHK("crit_oor", c == 31, oor)
			if (c != 31)
				`CHK("ocp_pct", c[0] ? e * 2 : (e * 5) / 4, ovr)
		end
		// clamp above 3.584A, and the boundary code that does not clamp
		for (int k = 0; k < 3; k++) begin
			prog = k < 2 ? 7'h39 : 7'h38;
			r0[15:11] = k == 1 ? 5'h1f : 5'h1e;
			put0();
			tick(5);
			`CHK("clamp_pct", k < 2 ? 230 : 450, pct)
			`CHK("clamp_oor", 1'b0, oor)
		end
		prog = 7'h20;
		r0[15:8] = 8'h4b;
		$display("test critical done");
		for (int k = 0; k < 8; k++) begin
			r0[7:6] = 2'(k);
			single = k[2];
			put0();
			tick(3);
			`CHK("system_voltage_comparator_mv", (k[2] ? 2850 : 5750) + 250 * k[1:0], mv)
		end
		r0[7:6] = 2'b01;
		$display("test voltage done");
		// deglitch times, pulse width 1 ms for quick release
		r0[4:3] = 2'b01;
		env = 7'h20;
		for (int i = 0; i < 4; i++) begin
			r0[10:9] = 2'(i);
			put0();
			measure(6, dgt[i] + 20);
			`CHK("crit_dly", 1'b1, d >= dgt[i] && d <= dgt[i] + 6)
			settle();
		end
		env = 7'h10;
		for (int i = 0; i < 2; i++) begin
			r0[1] = i[0];
			put0();
			measure(5, 130);
			e = i ? 100 : 40;
			`CHK("nom_dly", 1'b1, d >= e && d <= e + 6)
			settle();
		end
		env = 7'h04;
		measure(3, 700);
		`CHK("system_voltage_comparator_glitch", 700, d)
		settle();
		measure(3, 900);
		`CHK("system_voltage_comparator_dly", 1'b1, d >= 800 && d <= 806)
		settle();
		env = 7'h08;
		measure(4, 50);
		`CHK("dchg_dly", 1'b1, d <= 6)
		settle();
		env = 7'h02;
		measure(2, 50);
		`CHK("batp_dly", 1'b1, d <= 6)
		settle();
		// adapter good: a rise must stay quiet, the fall fires the one-shot
		env = 7'h01;
		measure(1, 20);
		`CHK("adapter_good_source_rise", 20, d)
		tick(4);
		`CHK("adapter_good_source_fall", 1'b0, alarm_n)
		settle();
		$display("test deglitch done");
		env = 7'h40;
		for (int i = 0; i < 4; i++) begin
			r0[4:3] = 2'(i);
			put0();
			measure(7, 4100);
			`CHK("pulse_w", 1'b1, w >= pwt[i] && w <= pwt[i] + 8)
			settle();
		end
		// extension holds the alarm until the host clears it
		r0[5:3] = 3'b101;
		put0();
		measure(7, 300);
		`CHK("ext_hold", 300, w)
		host.clear_alarm(r0);
		tick(3);
		`CHK("ext_clear", 1'b1, alarm_n)
		r0[5] = 1'b0;
		put0();
		settle();
		$display("test pulse done");
		// empty envelope, then adapter removal masking
		env = 7'h00;
		measure(7, 50);
		`CHK("env_off", 50, d)
		sense_v[0] = 1'b0;
		r0[10:9] = 2'b11;
		put0();
		env = 7'h72;
		measure(6, 100);
		`CHK("absent_crit", 100, d)
		measure(5, 200);
		`CHK("absent_nom", 200, d)
		measure(2, 100);
		`CHK("absent_batp", 100, d)
		measure(7, 50);
		`CHK("absent_cmp", 1'b1, d <= 6)
		settle();
		$display("test masking done");
		tick(5);
		stop_test();
	end
endmodule : tb_top
